// ---- hw/button_reset_watchdog_irq.sv ----
// Long-press supervisor, adapter watchdog and charger-flag interrupt front end.
// Assumes button and supply indications already synchronous to mclk.
`timescale 1ns/1ps
module button_reset_watchdog_irq #(
	parameter int LONG_PRESS_CYCLES = button_reset_pkg::LONG_PRESS_CYCLES, // Long press time in cycles
	parameter int WARN_CYCLES = button_reset_pkg::WARN_CYCLES, // Warn interval before expiry
	parameter longint WD_CYCLES = button_reset_pkg::WD_CYCLES, // Adapter watchdog window
	parameter int OFF_CYCLES = button_reset_pkg::POWER_OFF_CYCLES // Rail off time
) (
	input wire logic mclk, // Clock
	input wire logic rst_n, // Sync reset, low active
	input wire logic button_input_n, // Push button, low when pressed
	input wire logic [1:0] long_press_action_sel, // Long press action
	input wire logic reset_needs_adapter, // Gate long-press power cycle on adapter
	input wire logic adapter_valid, // Valid adapter supply
	input wire logic software_power_cycle, // Host write pulse
	input wire logic adapter_watchdog_enable, // Watchdog enable bit
	input wire logic i2c_transaction, // Pulse per I2C transaction
	input wire logic startup_done, // Start-up finished
	input wire logic startup_fault, // Start-up hit a fault
	input wire logic charge_terminated, // Termination reached
	input wire logic recharge_threshold, // Battery below recharge level
	input wire logic charge_enable, // Host charge enable
	input wire logic input_limit_active, // Input current loop active
	input wire logic power_path_foldback_active, // Foldback loop active
	input wire logic input_sag_active, // Input droop loop active
	input wire logic timer_double_en, // Safety timer double option
	input wire logic [4:0] irq_mask, // Per-source mask
	input wire logic [4:0] flag_read, // Flag read-clear pulses
	output logic system_rail_en, // System rail enable
	output logic io_supply_en, // I/O supply enable, on except in ship mode
	output logic ship_mode, // Ship mode request
	output logic reset_warning_flag, // Warning flag
	output logic charge_complete_flag, // Charge done flag
	output logic input_limit_flag, // Input limit flag
	output logic power_path_foldback_flag, // Foldback flag
	output logic input_sag_flag, // Input sag flag
	output logic charge_paused, // Charging paused
	output logic charge_reduce, // Reduced charge current
	output logic safety_timer_reset, // Safety timer restart pulse
	output logic safety_timer_double, // Safety timer doubled
	output logic int_n_o, // Interrupt pin output value
	output logic int_n_oe // Interrupt pin drive enable
);
	localparam int N = button_reset_pkg::SRC_COUNT;

	////////////////////////////////////////////////////////////////
	// Long press

	logic [$clog2(LONG_PRESS_CYCLES+1)-1:0] press_cnt_reg;
	logic pressing_reg;
	logic adapter_ok_reg;
	logic [1:0] action_reg;
	logic expire;
	logic warn_level;
	logic cycle_req;
	logic [N-1:0] flags;
	logic int_oe;

	assign expire = pressing_reg && !button_input_n &&
		press_cnt_reg == ($clog2(LONG_PRESS_CYCLES+1))'(LONG_PRESS_CYCLES - 1);
	assign warn_level = pressing_reg && !button_input_n &&
		press_cnt_reg >= ($clog2(LONG_PRESS_CYCLES+1))'(LONG_PRESS_CYCLES - WARN_CYCLES);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			press_cnt_reg <= '0;
			pressing_reg <= 1'b0;
		end else if (button_input_n) begin
			press_cnt_reg <= '0;
			pressing_reg <= 1'b0;
		end else if (!pressing_reg) begin
			press_cnt_reg <= '0;
			pressing_reg <= 1'b1;
		end else if (press_cnt_reg != ($clog2(LONG_PRESS_CYCLES+1))'(LONG_PRESS_CYCLES))
			// Parks one past expiry so a held button acts only once per press
			press_cnt_reg <= press_cnt_reg + 1'b1;
	end

	// Action is tracked live during the press; only a move to power cycle is refused
	always_ff @(posedge mclk) begin
		if (!rst_n)
			action_reg <= button_reset_pkg::ACTION_NONE;
		else if (!pressing_reg)
			action_reg <= long_press_action_sel;
		else if (long_press_action_sel != button_reset_pkg::ACTION_CYCLE ||
			action_reg == button_reset_pkg::ACTION_CYCLE)
			action_reg <= long_press_action_sel;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			adapter_ok_reg <= 1'b0;
		else if (!pressing_reg)
			adapter_ok_reg <= adapter_valid;
		else if (!adapter_valid)
			adapter_ok_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// Adapter watchdog

	logic [63:0] wd_cnt_reg;
	logic wd_arm_reg;
	logic adapter_prev_reg;
	logic wd_fire;

	assign wd_fire = wd_arm_reg && adapter_watchdog_enable && !i2c_transaction &&
		wd_cnt_reg == 64'(WD_CYCLES - 1);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			adapter_prev_reg <= 1'b0;
			wd_arm_reg <= 1'b0;
			wd_cnt_reg <= '0;
		end else begin
			adapter_prev_reg <= adapter_valid;
			if (!adapter_watchdog_enable || !adapter_valid || i2c_transaction || wd_fire) begin
				wd_arm_reg <= 1'b0;
				wd_cnt_reg <= '0;
			end else if (adapter_valid && !adapter_prev_reg) begin
				wd_arm_reg <= 1'b1;
				wd_cnt_reg <= '0;
			end else if (wd_arm_reg)
				wd_cnt_reg <= wd_cnt_reg + 64'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Power sequencing

	button_reset_pkg::power_state_t ps_reg;
	logic [$clog2(OFF_CYCLES+1)-1:0] off_cnt_reg;
	logic press_cycle;
	logic press_ship;

	assign press_ship = expire && action_reg[button_reset_pkg::ACTION_SHIP_BIT];
	assign press_cycle = expire && action_reg == button_reset_pkg::ACTION_CYCLE &&
		(!reset_needs_adapter || (adapter_ok_reg && adapter_valid));
	assign cycle_req = press_cycle || software_power_cycle || wd_fire;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ps_reg <= button_reset_pkg::PS_IDLE;
			off_cnt_reg <= '0;
			system_rail_en <= 1'b1;
			ship_mode <= 1'b0;
		end else begin
			case (ps_reg)
				button_reset_pkg::PS_IDLE: begin
					if (press_ship) begin
						ps_reg <= button_reset_pkg::PS_SHIP;
						system_rail_en <= 1'b0;
						ship_mode <= 1'b1;
					end else if (cycle_req) begin
						ps_reg <= button_reset_pkg::PS_OFF;
						system_rail_en <= 1'b0;
						off_cnt_reg <= ($clog2(OFF_CYCLES+1))'(OFF_CYCLES - 1);
					end
				end
				button_reset_pkg::PS_OFF: begin
					if (off_cnt_reg == '0) begin
						ps_reg <= button_reset_pkg::PS_IDLE;
						system_rail_en <= 1'b1;
					end else
						off_cnt_reg <= off_cnt_reg - 1'b1;
				end
				// Leaving ship mode is the wake logic's job, which ends in a reset
				button_reset_pkg::PS_SHIP: begin
					ship_mode <= 1'b1;
				end
				default: begin
					ps_reg <= button_reset_pkg::PS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			io_supply_en <= 1'b1;
		else
			io_supply_en <= ps_reg != button_reset_pkg::PS_SHIP;
	end

	////////////////////////////////////////////////////////////////
	// Charger response

	logic ce_prev_reg;
	logic adp_prev_reg;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ce_prev_reg <= 1'b0;
			adp_prev_reg <= 1'b0;
			charge_paused <= 1'b0;
			safety_timer_reset <= 1'b0;
		end else begin
			ce_prev_reg <= charge_enable;
			adp_prev_reg <= adapter_valid;
			safety_timer_reset <= 1'b0;
			if (charge_terminated && !charge_paused) begin
				charge_paused <= 1'b1;
				safety_timer_reset <= 1'b1;
			end else if (charge_paused && (charge_enable != ce_prev_reg ||
				adapter_valid != adp_prev_reg || recharge_threshold))
				charge_paused <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			charge_reduce <= 1'b0;
			safety_timer_double <= 1'b0;
		end else begin
			charge_reduce <= input_limit_active | power_path_foldback_active | input_sag_active;
			safety_timer_double <= timer_double_en &
				(input_limit_active | power_path_foldback_active | input_sag_active);
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupts

	logic start_ok_reg;

	always_ff @(posedge mclk) begin
		if (!rst_n)
			start_ok_reg <= 1'b0;
		else
			start_ok_reg <= startup_done & ~startup_fault;
	end

	irq_pulser #(
		.N(N),
		.PULSE_CYCLES(button_reset_pkg::PULSE_CYCLES)
	) u_irq (
		.mclk(mclk),
		.rst_n(rst_n),
		.status({input_sag_active, power_path_foldback_active, input_limit_active,
			charge_terminated, warn_level}),
		.mask(irq_mask),
		.read_clear(flag_read),
		.start_ok(start_ok_reg),
		.flags(flags),
		.int_oe(int_oe)
	);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			int_n_oe <= 1'b0;
			int_n_o <= 1'b0;
			reset_warning_flag <= 1'b0;
			charge_complete_flag <= 1'b0;
			input_limit_flag <= 1'b0;
			power_path_foldback_flag <= 1'b0;
			input_sag_flag <= 1'b0;
		end else begin
			int_n_oe <= int_oe;
			int_n_o <= 1'b0;
			reset_warning_flag <= flags[button_reset_pkg::SRC_WARN];
			charge_complete_flag <= flags[button_reset_pkg::SRC_DONE];
			input_limit_flag <= flags[button_reset_pkg::SRC_ILIM];
			power_path_foldback_flag <= flags[button_reset_pkg::SRC_FOLD];
			input_sag_flag <= flags[button_reset_pkg::SRC_SAG];
		end
	end
endmodule : button_reset_watchdog_irq

// ---- shared/button_reset_pkg.sv ----
// Constants and types for the long-press supervisor, adapter watchdog and interrupt pulser.
// Assumes a single 250 MHz clock; all control bits arrive as plain ports.
package button_reset_pkg;

	localparam int CLK_MHZ = 250;
	localparam int LONG_PRESS_CYCLES = 25000;
	localparam int WARN_CYCLES = 5000;
	localparam int PULSE_US = 128;
	localparam int PULSE_CYCLES = PULSE_US * CLK_MHZ;
	localparam int WD_SECONDS = 14;
	localparam longint WD_CYCLES = longint'(WD_SECONDS) * 64'd1000000 * CLK_MHZ;
	localparam int POWER_OFF_US = 100;
	localparam int POWER_OFF_CYCLES = POWER_OFF_US * CLK_MHZ;

	localparam logic [1:0] ACTION_CYCLE = 2'h0;
	localparam logic [1:0] ACTION_NONE = 2'h1;
	localparam int ACTION_SHIP_BIT = 1;

	localparam int SRC_COUNT = 5;
	localparam int SRC_WARN = 0;
	localparam int SRC_DONE = 1;
	localparam int SRC_ILIM = 2;
	localparam int SRC_FOLD = 3;
	localparam int SRC_SAG = 4;
	localparam logic [SRC_COUNT-1:0] FLAGS_RESET = 5'h00;

	typedef enum logic [1:0] {
		PS_IDLE,
		PS_OFF,
		PS_SHIP
	} power_state_t;

endpackage : button_reset_pkg

// ---- hw/irq_pulser.sv ----
// Sticky flags with masks and a timed open-drain interrupt pulse.
// Assumes status inputs synchronous to mclk.
`timescale 1ns/1ps
module irq_pulser #(
	parameter int N = button_reset_pkg::SRC_COUNT,
	parameter int PULSE_CYCLES = button_reset_pkg::PULSE_CYCLES
) (
	input wire logic mclk, // Clock
	input wire logic rst_n, // Sync reset, low active
	input wire logic [N-1:0] status, // Live status bits
	input wire logic [N-1:0] mask, // 1 masks a source
	input wire logic [N-1:0] read_clear, // Host read of flags, one pulse
	input wire logic start_ok, // Start-up completed without fault
	output logic [N-1:0] flags, // Sticky flags
	output logic int_oe // Drives pin low while high
);
	logic [N-1:0] status_reg;
	logic [N-1:0] trig;
	logic [$clog2(PULSE_CYCLES+1)-1:0] cnt_reg;

	always_ff @(posedge mclk) begin
		if (!rst_n)
			status_reg <= '0;
		else
			status_reg <= status;
	end

	generate
		for (genvar i = 0; i < N; i++) begin : g_src
			// Set beats a read in the same cycle
			assign trig[i] = status[i] & ~status_reg[i] & ~flags[i] & ~mask[i] & start_ok;
			always_ff @(posedge mclk) begin
				if (!rst_n)
					flags[i] <= button_reset_pkg::FLAGS_RESET[i];
				else if (status[i] & ~status_reg[i])
					flags[i] <= 1'b1;
				else if (read_clear[i])
					flags[i] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			int_oe <= 1'b0;
		end else if (|trig && cnt_reg == '0) begin
			cnt_reg <= ($clog2(PULSE_CYCLES+1))'(PULSE_CYCLES - 1);
			int_oe <= 1'b1;
		end else if (cnt_reg != '0) begin
			// New triggers while active merge into the running pulse
			cnt_reg <= cnt_reg - 1'b1;
			int_oe <= 1'b1;
		end else
			int_oe <= 1'b0;
	end
endmodule : irq_pulser

// ---- tb/button_host_model.sv ----
// Push button and interrupt pull-up seen from the host side.
// Assumes mclk from the bench; press requests arrive as a one-cycle go pulse.
`timescale 1ns/1ps
module button_host_model (
	input wire logic mclk, // Clock
	input wire logic go, // Start a press
	input wire logic [31:0] len, // Press length in cycles
	input wire logic int_n_o, // Pin value from the block
	input wire logic int_n_oe, // Pin drive enable
	output logic button_input_n, // Button, low while pressed
	output logic int_line // Resolved interrupt wire
);
	int left = 0;
	// Button moves only on falling edges, away from the sampling edge
	always @(negedge mclk) begin
		if (go)
			left <= len;
		else if (left > 0)
			left <= left - 1;
	end
	assign button_input_n = (left == 0);
	// External pull-up holds the released open-drain pin high
	assign int_line = int_n_oe ? int_n_o : 1'b1;
endmodule : button_host_model

// ---- tb/button_reset_watchdog_irq_checker.sv ----
// Concurrent checks on the supervisor top-level ports.
// Assumes the bench leaves start-up stable around each interrupt.
`timescale 1ns/1ps
module button_reset_watchdog_irq_checker #(
	parameter int PULSE_CYCLES = button_reset_pkg::PULSE_CYCLES
) (
	input wire logic mclk, // Clock
	input wire logic rst_n, // Sync reset
	input wire logic software_power_cycle, // Host pulse
	input wire logic startup_done, // Start-up finished
	input wire logic startup_fault, // Start-up fault
	input wire logic charge_terminated, // Termination
	input wire logic input_limit_active, // Input limit loop
	input wire logic input_sag_active, // Sag loop
	input wire logic timer_double_en, // Double option
	input wire logic [4:0] irq_mask, // Masks
	input wire logic [4:0] flag_read, // Read-clear
	input wire logic system_rail_en, // Rail enable
	input wire logic io_supply_en, // I/O supply
	input wire logic ship_mode, // Ship mode
	input wire logic input_limit_flag, // Limit flag
	input wire logic input_sag_flag, // Sag flag
	input wire logic charge_paused, // Paused
	input wire logic safety_timer_reset, // Timer restart
	input wire logic safety_timer_double, // Timer doubled
	input wire logic int_n_o, // Pin value
	input wire logic int_n_oe // Pin enable
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	int pulse_len;
	always_ff @(posedge mclk) begin
		if (!rst_n || !int_n_oe)
			pulse_len <= 0;
		else
			pulse_len <= pulse_len + 1;
	end
	sequence sag_trig;
		$rose(input_sag_active) && !irq_mask[4] && !input_sag_flag && !int_n_oe &&
			$past(startup_done) && !$past(startup_fault);
	endsequence
	sequence rail_off_run;
		!system_rail_en [*8];
	endsequence
	io_always_on_a: assert property (!ship_mode |-> io_supply_en) else $error("io supply dropped");
	pin_low_only_a: assert property (int_n_oe |-> !int_n_o) else $error("pin driven high");
	pulse_exact_a: assert property ($fell(int_n_oe) |-> pulse_len == PULSE_CYCLES) else $error("pulse length");
	int_after_start_a: assert property ($rose(int_n_oe) |-> startup_done && !startup_fault)
		else $error("interrupt before start-up");
	sag_pulse_a: assert property (sag_trig |-> ##2 int_n_oe) else $error("sag edge gave no pulse");
	rail_off_a: assert property ($fell(system_rail_en) |-> rail_off_run) else $error("rail off too short");
	sw_cycle_a: assert property (software_power_cycle && system_rail_en && !ship_mode |-> ##[1:3] !system_rail_en)
		else $error("software cycle ignored");
	ship_hold_a: assert property (ship_mode |=> ship_mode) else $error("ship mode left");
	flag_sticky_a: assert property (input_limit_flag && !flag_read[2] && !$past(flag_read[2]) |=> input_limit_flag)
		else $error("flag lost");
	limit_flag_a: assert property ($rose(input_limit_active) |-> ##2 input_limit_flag) else $error("limit flag");
	timer_double_a: assert property (input_limit_active && timer_double_en |-> ##[1:2] safety_timer_double)
		else $error("timer not doubled");
	done_pause_a: assert property ($rose(charge_terminated) && !charge_paused |=> charge_paused && safety_timer_reset)
		else $error("no pause at termination");
endmodule : button_reset_watchdog_irq_checker
bind button_reset_watchdog_irq button_reset_watchdog_irq_checker chk_i (.mclk, .rst_n, .software_power_cycle,
	.startup_done, .startup_fault, .charge_terminated, .input_limit_active, .input_sag_active, .timer_double_en,
	.irq_mask, .flag_read, .system_rail_en, .io_supply_en, .ship_mode, .input_limit_flag, .input_sag_flag,
	.charge_paused, .safety_timer_reset, .safety_timer_double, .int_n_o, .int_n_oe);

// ---- tb/button_reset_watchdog_irq_tb.sv ----
// Directed bench for the long-press supervisor, watchdog and interrupt pulser.
// Assumes short counts: press 40, warn 10, watchdog 50, rail off 8 cycles.
`timescale 1ns/1ps
module button_reset_watchdog_irq_tb;
	logic mclk = 0, rst_n = 0, go = 0, btn, int_line, oe, pin;
	logic [1:0] sel = 2'h1;
	logic rna = 0, adp = 1, sw = 0, wd_en = 0, i2c = 0, st_done = 0, st_fault = 0, term = 0, rch = 0, ce = 1;
	logic ilim = 0, fold = 0, sag = 0, dbl = 0;
	logic [4:0] mask = 5'h00, rd = 5'h00;
	logic rail, io, ship, warn_f, done_f, ilim_f, fold_f, sag_f, paused, reduce, str, sdbl;
	int plen = 45, error_cnt = 0, samples_checked = 0, cycles = 0;
	initial forever #2 mclk = ~mclk;
	button_host_model host (.mclk(mclk), .go(go), .len(plen), .int_n_o(pin), .int_n_oe(oe),
		.button_input_n(btn), .int_line(int_line));
	button_reset_watchdog_irq #(.LONG_PRESS_CYCLES(40), .WARN_CYCLES(10), .WD_CYCLES(50), .OFF_CYCLES(8)) uut (
		.mclk(mclk), .rst_n(rst_n), .button_input_n(btn), .long_press_action_sel(sel), .reset_needs_adapter(rna),
		.adapter_valid(adp), .software_power_cycle(sw), .adapter_watchdog_enable(wd_en), .i2c_transaction(i2c),
		.startup_done(st_done), .startup_fault(st_fault), .charge_terminated(term), .recharge_threshold(rch),
		.charge_enable(ce), .input_limit_active(ilim), .power_path_foldback_active(fold), .input_sag_active(sag),
		.timer_double_en(dbl), .irq_mask(mask), .flag_read(rd), .system_rail_en(rail), .io_supply_en(io),
		.ship_mode(ship), .reset_warning_flag(warn_f), .charge_complete_flag(done_f), .input_limit_flag(ilim_f),
		.power_path_foldback_flag(fold_f), .input_sag_flag(sag_f), .charge_paused(paused), .charge_reduce(reduce),
		.safety_timer_reset(str), .safety_timer_double(sdbl), .int_n_o(pin), .int_n_oe(oe));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic seen, input logic exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %b seen %b", nm, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc
	// Watches for a rail drop, then lets any power cycle finish
	task automatic drop(input int n, input logic exp, input string nm);
		logic got;
		got = 0;
		repeat (n) begin
			@(negedge mclk);
			if (rail === 1'b0)
				got = 1;
		end
		chk(nm, got, exp);
		cyc(12);
	endtask : drop
	task automatic press();
		go <= 1;
		@(negedge mclk);
		go <= 0;
	endtask : press
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 80000) begin
			error_cnt++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic t_startup();
		chk("rail reset", rail, 1);
		chk("warn reset", warn_f, 0);
		sag <= 1;
		cyc(5);
		chk("int before start", int_line, 1);
		sag <= 0;
		st_done <= 1;
		st_fault <= 1;
		cyc(3);
		sag <= 1;
		cyc(5);
		chk("int after fault start", int_line, 1);
		sag <= 0;
		st_fault <= 0;
		rd <= 5'h1F;
		cyc(1);
		rd <= 5'h00;
		cyc(3);
		$display("startup done");
	endtask : t_startup
	task automatic t_presses();
		sw <= 1;
		cyc(1);
		sw <= 0;
		chk("io in cycle", io, 1);
		drop(4, 1, "sw cycle");
		sel <= 2'h0;
		press();
		drop(50, 1, "press cycle");
		chk("warn flag", warn_f, 1);
		chk("warn int", int_line, 0);
		sel <= 2'h1;
		press();
		cyc(20);
		sel <= 2'h0;
		drop(50, 0, "refused change");
		rna <= 1;
		press();
		cyc(10);
		adp <= 0;
		cyc(2);
		adp <= 1;
		drop(70, 0, "gated cycle");
		rna <= 0;
		$display("presses done");
	endtask : t_presses
	task automatic t_watchdog();
		wd_en <= 1;
		adp <= 0;
		cyc(2);
		adp <= 1;
		cyc(20);
		i2c <= 1;
		cyc(1);
		i2c <= 0;
		drop(70, 0, "wd cancel");
		adp <= 0;
		cyc(2);
		adp <= 1;
		drop(70, 1, "wd fire");
		wd_en <= 0;
		$display("watchdog done");
	endtask : t_watchdog
	task automatic t_irq();
		int n;
		n = 0;
		while (int_line !== 1'b1 && n < 33000) begin
			cyc(1);
			n++;
		end
		mask <= 5'h08;
		fold <= 1;
		cyc(4);
		chk("masked", int_line, 1);
		chk("fold flag", fold_f, 1);
		mask <= 5'h00;
		cyc(4);
		chk("unmasked", int_line, 1);
		sag <= 1;
		cyc(3);
		chk("sag int", int_line, 0);
		chk("sag flag", sag_f, 1);
		dbl <= 1;
		ilim <= 1;
		cyc(3);
		chk("limit flag", ilim_f, 1);
		chk("reduce", reduce, 1);
		term <= 1;
		cyc(2);
		chk("paused", paused, 1);
		chk("done flag", done_f, 1);
		term <= 0;
		rch <= 1;
		cyc(2);
		chk("resumed", paused, 0);
		rch <= 0;
		n = 0;
		while (int_line !== 1'b1 && n < 33000) begin
			cyc(1);
			n++;
		end
		cyc(4);
		chk("merged", int_line, 1);
		$display("interrupts done");
	endtask : t_irq
	task automatic t_ship();
		sel <= 2'h0;
		press();
		cyc(15);
		sel <= 2'h2;
		cyc(40);
		chk("ship", ship, 1);
		$display("ship done");
	endtask : t_ship
	initial begin
		cyc(10);
		rst_n <= 1;
		cyc(2);
		t_startup();
		t_presses();
		t_watchdog();
		t_irq();
		t_ship();
		results();
	end
endmodule : button_reset_watchdog_irq_tb
